// >>> rtl/btr_top.sv
// Branch trace recorder: stack, last exception pair, stepping and trace store.
`default_nettype none
module btr_top #(
    parameter logic STORE_ABSENT = 1'b0
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic             pready_q,
    output logic [31:0]      prdata_q,
    output logic             pslverr_q,
    input  wire logic        ev_valid,
    input  wire logic [1:0]  ev_kind,
    input  wire logic [31:0] ev_from,
    input  wire logic [31:0] ev_to,
    input  wire logic        ev_with_branch,
    input  wire logic [31:0] ev_br_from,
    input  wire logic [31:0] ev_br_to,
    input  wire logic        dbg_exc,
    output logic             core_ready_q,
    output logic             step_trap_q,
    output logic             trace_irq_q,
    output logic             msg_valid_q,
    output logic [31:0]      msg_from_q,
    output logic [31:0]      msg_to_q,
    input  wire logic        msg_ready,
    output logic             mem_valid_q,
    output logic [31:0]      mem_addr_q,
    output logic [63:0]      mem_data_q,
    input  wire logic        mem_ready
);
    localparam int unsigned DEPTH = btr_pkg::STACK_DEPTH;

    btr_emit_if em ();

    logic [4:0]  ctl_q, ctl_d;
    logic        tf_q, tf_d;
    logic [1:0]  tos_q, tos_d;
    logic [31:0] sfrom_q [DEPTH];
    logic [31:0] sto_q   [DEPTH];
    logic [31:0] sfrom_d [DEPTH];
    logic [31:0] sto_d   [DEPTH];
    logic [31:0] ler_dst_q, ler_dst_d, ler_src_q, ler_src_d;
    logic [31:0] lb_from_q, lb_from_d, lb_to_q, lb_to_d;
    logic [31:0] sap_q, sap_d, base_q, base_d, idx_q, idx_d;
    logic [31:0] max_q, max_d, thr_q, thr_d;
    logic        trap_d, irq_d, rdy_d, err_d;
    logic [31:0] rd_d, nidx;
    logic        acc, wr, take, pair, msg_on, circ;
    logic [7:0]  off;

    function automatic logic is_handler_kind(input logic [1:0] k);
        return (k == btr_pkg::BTR_KIND_IRQ) || (k == btr_pkg::BTR_KIND_EXC);
    endfunction

    assign off    = paddr[7:0];
    assign acc    = psel && penable && pready_q;
    assign wr     = acc && pwrite;
    assign take   = ev_valid && core_ready_q;
    assign pair   = ev_with_branch && is_handler_kind(ev_kind);
    // Trace message enable gates both destinations.
    assign msg_on = ctl_q[btr_pkg::CTL_MSG];
    assign circ   = !ctl_q[btr_pkg::CTL_IRQ];
    assign nidx   = idx_q + 32'(btr_pkg::REC_BYTES);

    // One destination only, chosen by the memory flag.
    assign em.push      = take && msg_on;
    assign em.to_mem    = ctl_q[btr_pkg::CTL_MEM];
    assign em.two       = pair;
    assign em.rec0_from = pair ? ev_br_from : ev_from;
    assign em.rec0_to   = pair ? ev_br_to : ev_to;
    assign em.rec1_from = ev_from;
    assign em.rec1_to   = ev_to;
    assign em.wr_addr   = idx_q;
    assign em.mem_full  = circ ? 1'b0 : (idx_q >= max_q);

    always_comb begin
        ctl_d     = ctl_q;
        tf_d      = tf_q;
        tos_d     = tos_q;
        sfrom_d   = sfrom_q;
        sto_d     = sto_q;
        ler_dst_d = ler_dst_q;
        ler_src_d = ler_src_q;
        lb_from_d = lb_from_q;
        lb_to_d   = lb_to_q;
        sap_d     = sap_q;
        base_d    = base_q;
        idx_d     = idx_q;
        max_d     = max_q;
        thr_d     = thr_q;
        trap_d    = 1'b0;
        if (wr) begin
            unique case (off)
                btr_pkg::OFF_CTRL: begin
                    ctl_d = pwdata[4:0];
                    if (STORE_ABSENT) begin
                        ctl_d[btr_pkg::CTL_MEM] = 1'b0;
                        ctl_d[btr_pkg::CTL_IRQ] = 1'b0;
                    end
                end
                btr_pkg::OFF_TRAP:   tf_d   = pwdata[0];
                btr_pkg::OFF_SAP:    sap_d  = pwdata;
                btr_pkg::OFF_BASE:   base_d = pwdata;
                btr_pkg::OFF_INDEX:  idx_d  = pwdata;
                btr_pkg::OFF_ABSMAX: max_d  = pwdata;
                btr_pkg::OFF_THRESH: thr_d  = pwdata;
                default: ;
            endcase
        end
        if (take && ctl_q[btr_pkg::CTL_LOG]) begin
            if (pair) begin
                // Two pushes: branch first, then the handler entry.
                sfrom_d[2'(tos_q + 2'd1)] = ev_br_from;
                sto_d[2'(tos_q + 2'd1)]   = ev_br_to;
                sfrom_d[2'(tos_q + 2'd2)] = ev_from;
                sto_d[2'(tos_q + 2'd2)]   = ev_to;
                tos_d = tos_q + 2'd2;
            end else begin
                sfrom_d[2'(tos_q + 2'd1)] = ev_from;
                sto_d[2'(tos_q + 2'd1)]   = ev_to;
                tos_d = tos_q + 2'd1;
            end
            if (is_handler_kind(ev_kind)) begin
                // Last branch before the exception or interrupt.
                ler_src_d = pair ? ev_br_from : lb_from_q;
                ler_dst_d = pair ? ev_br_to : lb_to_q;
                lb_from_d = ler_src_d;
                lb_to_d   = ler_dst_d;
            end else begin
                lb_from_d = ev_from;
                lb_to_d   = ev_to;
            end
        end
        if (take && ctl_q[btr_pkg::CTL_STEP] && tf_q) begin
            trap_d = 1'b1;
        end
        // The hardware clear beats a same-cycle software write for the log bit, and for step only when step was already set.
        if (dbg_exc) begin
            ctl_d[btr_pkg::CTL_LOG] = 1'b0;
            if (ctl_q[btr_pkg::CTL_STEP]) begin
                ctl_d[btr_pkg::CTL_STEP] = 1'b0;
                tf_d = 1'b0;
            end
        end
        if (em.mem_done) begin
            // Advance by one record, wrapping only in circular mode.
            idx_d = (circ && nidx >= max_q) ? base_q : nidx;
        end
        // Level request while the index sits at or past the threshold.
        irq_d = msg_on && ctl_q[btr_pkg::CTL_MEM]
                && ctl_q[btr_pkg::CTL_IRQ] && (idx_d >= thr_d);
    end

    always_comb begin
        rd_d  = btr_pkg::WORD_RESET;
        err_d = 1'b0;
        rdy_d = psel && penable && !pready_q;
        unique case (off)
            btr_pkg::OFF_CTRL:    rd_d = {27'h000_0000, ctl_q};
            btr_pkg::OFF_TRAP:    rd_d = {31'h0000_0000, tf_q};
            btr_pkg::OFF_TOS:     rd_d = {30'h0000_0000, tos_q};
            btr_pkg::OFF_CAP:     rd_d[btr_pkg::DS_CAP_BIT] = 1'b1;
            btr_pkg::OFF_LER_DST: rd_d = ler_dst_q;
            btr_pkg::OFF_LER_SRC: rd_d = ler_src_q;
            btr_pkg::OFF_SAP:     rd_d = sap_q;
            btr_pkg::OFF_MISC:    rd_d[btr_pkg::MISC_ABSENT_BIT] = STORE_ABSENT;
            btr_pkg::OFF_BASE:    rd_d = base_q;
            btr_pkg::OFF_INDEX:   rd_d = idx_q;
            btr_pkg::OFF_ABSMAX:  rd_d = max_q;
            btr_pkg::OFF_THRESH:  rd_d = thr_q;
            default: begin
                err_d = 1'b1;
                for (int i = 0; i < DEPTH; i++) begin
                    if (off == btr_pkg::OFF_STACK + 8'(8 * i)) begin
                        rd_d  = sfrom_q[i];
                        err_d = 1'b0;
                    end
                    if (off == btr_pkg::OFF_STACK + 8'(8 * i + 4)) begin
                        rd_d  = sto_q[i];
                        err_d = 1'b0;
                    end
                end
                // Stack and pointer are read only; other holes answer error.
                if (paddr[31:8] != 24'h00_0000) begin
                    err_d = 1'b1;
                end
            end
        endcase
        if (paddr[31:8] != 24'h00_0000 || paddr[1:0] != 2'b00) begin
            err_d = 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctl_q       <= btr_pkg::CTRL_RESET;
            tf_q        <= 1'b0;
            tos_q       <= 2'd0;
            for (int i = 0; i < DEPTH; i++) begin
                sfrom_q[i] <= btr_pkg::WORD_RESET;
                sto_q[i]   <= btr_pkg::WORD_RESET;
            end
            ler_dst_q   <= btr_pkg::WORD_RESET;
            ler_src_q   <= btr_pkg::WORD_RESET;
            lb_from_q   <= btr_pkg::WORD_RESET;
            lb_to_q     <= btr_pkg::WORD_RESET;
            sap_q       <= btr_pkg::WORD_RESET;
            base_q      <= btr_pkg::WORD_RESET;
            idx_q       <= btr_pkg::WORD_RESET;
            max_q       <= btr_pkg::WORD_RESET;
            thr_q       <= btr_pkg::WORD_RESET;
            step_trap_q <= 1'b0;
            trace_irq_q <= 1'b0;
            core_ready_q <= 1'b0;
            pready_q    <= 1'b0;
            prdata_q    <= btr_pkg::WORD_RESET;
            pslverr_q   <= 1'b0;
        end else begin
            ctl_q       <= ctl_d;
            tf_q        <= tf_d;
            tos_q       <= tos_d;
            sfrom_q     <= sfrom_d;
            sto_q       <= sto_d;
            ler_dst_q   <= ler_dst_d;
            ler_src_q   <= ler_src_d;
            lb_from_q   <= lb_from_d;
            lb_to_q     <= lb_to_d;
            sap_q       <= sap_d;
            base_q      <= base_d;
            idx_q       <= idx_d;
            max_q       <= max_d;
            thr_q       <= thr_d;
            step_trap_q <= trap_d;
            trace_irq_q <= irq_d;
            // Ready drops for the cycle after a take so the emitter can latch, and stays low until the emitter is idle.
            core_ready_q <= em.idle && !take;
            pready_q    <= rdy_d;
            prdata_q    <= rd_d;
            pslverr_q   <= rdy_d && err_d;
        end
    end

    btr_emit u_emit (
        .pclk        (pclk),
        .presetn     (presetn),
        .em          (em),
        .msg_valid_q (msg_valid_q),
        .msg_from_q  (msg_from_q),
        .msg_to_q    (msg_to_q),
        .msg_ready   (msg_ready),
        .mem_valid_q (mem_valid_q),
        .mem_addr_q  (mem_addr_q),
        .mem_data_q  (mem_data_q),
        .mem_ready   (mem_ready)
    );
endmodule
`default_nettype wire

// >>> rtl/btr_pkg.sv
// Constants and types shared by the branch trace recorder files.
`default_nettype none
package btr_pkg;
    localparam int unsigned STACK_DEPTH = 4;
    localparam int unsigned REC_BYTES   = 8;
    localparam int unsigned DS_CAP_BIT  = 21;

    localparam logic [7:0] OFF_CTRL    = 8'h00;
    localparam logic [7:0] OFF_TRAP    = 8'h04;
    localparam logic [7:0] OFF_TOS     = 8'h08;
    localparam logic [7:0] OFF_CAP     = 8'h0C;
    localparam logic [7:0] OFF_STACK   = 8'h10;
    localparam logic [7:0] OFF_LER_DST = 8'h30;
    localparam logic [7:0] OFF_LER_SRC = 8'h34;
    localparam logic [7:0] OFF_SAP     = 8'h38;
    localparam logic [7:0] OFF_MISC    = 8'h3C;
    localparam logic [7:0] OFF_BASE    = 8'h40;
    localparam logic [7:0] OFF_INDEX   = 8'h44;
    localparam logic [7:0] OFF_ABSMAX  = 8'h48;
    localparam logic [7:0] OFF_THRESH  = 8'h4C;

    localparam int unsigned CTL_LOG  = 0;
    localparam int unsigned CTL_STEP = 1;
    localparam int unsigned CTL_MSG  = 2;
    localparam int unsigned CTL_MEM  = 3;
    localparam int unsigned CTL_IRQ  = 4;
    localparam int unsigned MISC_ABSENT_BIT = 0;

    localparam logic [4:0]  CTRL_RESET = 5'h00;
    localparam logic [31:0] WORD_RESET = 32'h0000_0000;

    typedef enum logic [1:0] {
        BTR_KIND_BRANCH = 2'b00,
        BTR_KIND_IRQ    = 2'b01,
        BTR_KIND_EXC    = 2'b10
    } btr_kind_t;
endpackage
`default_nettype wire

// >>> rtl/btr_emit_if.sv
// Link between the recorder core and its trace record emitter.
`default_nettype none
interface btr_emit_if;
    logic        push;
    logic        to_mem;
    logic        two;
    logic [31:0] rec0_from;
    logic [31:0] rec0_to;
    logic [31:0] rec1_from;
    logic [31:0] rec1_to;
    logic        idle;
    logic [31:0] wr_addr;
    logic        mem_full;
    logic        mem_done;
    modport core (output push, to_mem, two, rec0_from, rec0_to,
                  rec1_from, rec1_to, wr_addr, mem_full,
                  input idle, mem_done);
    modport emit (input push, to_mem, two, rec0_from, rec0_to,
                  rec1_from, rec1_to, wr_addr, mem_full,
                  output idle, mem_done);
endinterface
`default_nettype wire

// >>> rtl/btr_emit.sv
// Sends queued trace records to the system bus or to the store buffer.
`default_nettype none
module btr_emit (
    input  wire logic        pclk,
    input  wire logic        presetn,
    btr_emit_if.emit         em,
    output logic             msg_valid_q,
    output logic [31:0]      msg_from_q,
    output logic [31:0]      msg_to_q,
    input  wire logic        msg_ready,
    output logic             mem_valid_q,
    output logic [31:0]      mem_addr_q,
    output logic [63:0]      mem_data_q,
    input  wire logic        mem_ready
);
    logic [1:0]  cnt_q, cnt_d;
    logic        dst_q, dst_d;
    logic [31:0] f0_q, t0_q, f1_q, t1_q;
    logic [31:0] f0_d, t0_d, f1_d, t1_d;
    logic        mv_d, bv_d, idle_d;
    logic [31:0] mf_d, mt_d, ma_d;
    logic [63:0] md_d;
    logic        done_d;
    logic        idle_q, done_q;
    logic        busy;

    assign busy        = msg_valid_q | mem_valid_q;
    assign em.idle     = idle_q;
    assign em.mem_done = done_q;

    always_comb begin
        cnt_d  = cnt_q;
        dst_d  = dst_q;
        f0_d   = f0_q;
        t0_d   = t0_q;
        f1_d   = f1_q;
        t1_d   = t1_q;
        bv_d   = msg_valid_q;
        mv_d   = mem_valid_q;
        mf_d   = msg_from_q;
        mt_d   = msg_to_q;
        ma_d   = mem_addr_q;
        md_d   = mem_data_q;
        done_d = 1'b0;
        if (msg_valid_q && msg_ready) begin
            bv_d = 1'b0;
        end
        if (mem_valid_q && mem_ready) begin
            mv_d   = 1'b0;
            done_d = 1'b1;
        end
        if (em.push) begin
            // The second record follows the first, as on the stack.
            cnt_d = em.two ? 2'd2 : 2'd1;
            dst_d = em.to_mem;
            f0_d  = em.rec0_from;
            t0_d  = em.rec0_to;
            f1_d  = em.rec1_from;
            t1_d  = em.rec1_to;
        end else if (!busy && !done_q && cnt_q != 2'd0) begin
            // Launch waits a cycle after a store so the index has moved.
            if (!dst_q) begin
                bv_d = 1'b1;
                mf_d = f0_q;
                mt_d = t0_q;
            end else if (!em.mem_full) begin
                mv_d = 1'b1;
                ma_d = em.wr_addr;
                md_d = {t0_q, f0_q};
            end
            // A full non-circular buffer drops the record.
            cnt_d = cnt_q - 2'd1;
            f0_d  = f1_q;
            t0_d  = t1_q;
        end
        idle_d = (cnt_d == 2'd0) && !bv_d && !mv_d && !em.push;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q       <= 2'd0;
            dst_q       <= 1'b0;
            f0_q        <= btr_pkg::WORD_RESET;
            t0_q        <= btr_pkg::WORD_RESET;
            f1_q        <= btr_pkg::WORD_RESET;
            t1_q        <= btr_pkg::WORD_RESET;
            msg_valid_q <= 1'b0;
            mem_valid_q <= 1'b0;
            msg_from_q  <= btr_pkg::WORD_RESET;
            msg_to_q    <= btr_pkg::WORD_RESET;
            mem_addr_q  <= btr_pkg::WORD_RESET;
            mem_data_q  <= {btr_pkg::WORD_RESET, btr_pkg::WORD_RESET};
            idle_q      <= 1'b1;
            done_q      <= 1'b0;
        end else begin
            cnt_q       <= cnt_d;
            dst_q       <= dst_d;
            f0_q        <= f0_d;
            t0_q        <= t0_d;
            f1_q        <= f1_d;
            t1_q        <= t1_d;
            msg_valid_q <= bv_d;
            mem_valid_q <= mv_d;
            msg_from_q  <= mf_d;
            msg_to_q    <= mt_d;
            mem_addr_q  <= ma_d;
            mem_data_q  <= md_d;
            idle_q      <= idle_d;
            done_q      <= done_d;
        end
    end
endmodule
`default_nettype wire

// >>> tb/btr_monitor.sv
// Port assertions for the branch trace recorder, bound to its top module.
`default_nettype none
module btr_monitor (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic        pready_q,
    input wire logic        ev_valid,
    input wire logic        core_ready_q,
    input wire logic        step_trap_q,
    input wire logic        trace_irq_q,
    input wire logic        msg_valid_q,
    input wire logic [31:0] msg_from_q,
    input wire logic [31:0] msg_to_q,
    input wire logic        msg_ready,
    input wire logic        mem_valid_q,
    input wire logic [31:0] mem_addr_q,
    input wire logic [63:0] mem_data_q,
    input wire logic        mem_ready
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking mon_cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    logic take;
    logic wr_done;
    logic mem_acc;
    assign take    = ev_valid && core_ready_q;
    assign wr_done = psel && penable && pready_q && pwrite;
    assign mem_acc = mem_valid_q && mem_ready;
    chk_take_busy: assert property (take |=> !core_ready_q)
        else $error("core ready stayed high after a take");
    chk_step_cause: assert property
        (step_trap_q |-> $past(take) ##1 !step_trap_q)
        else $error("step trap without a take just before");
    chk_launch_cause: assert property
        ($rose(msg_valid_q) |-> $past(take, 2) || $past(take, 3) ||
         $past(msg_valid_q, 2) || $past(msg_valid_q, 3) ||
         $past(msg_valid_q, 4))
        else $error("trace message launched without a cause");
    chk_apb_wait: assert property
        ($rose(penable) && psel |-> !pready_q ##1 pready_q)
        else $error("register access did not take one wait state");
    chk_resp_pulse: assert property
        (pready_q |-> psel && penable ##1 !pready_q)
        else $error("ready outside an access or longer than a cycle");
    chk_msg_hold: assert property
        (msg_valid_q && !msg_ready |=> msg_valid_q &&
         $stable(msg_from_q) && $stable(msg_to_q))
        else $error("trace message changed before acceptance");
    chk_mem_hold: assert property
        (mem_valid_q && !mem_ready |=> mem_valid_q &&
         $stable(mem_addr_q) && $stable(mem_data_q))
        else $error("store write changed before acceptance");
    chk_one_dest: assert property (!(msg_valid_q && mem_valid_q))
        else $error("record sent to bus and store together");
    chk_irq_cause: assert property
        ($changed(trace_irq_q) |-> $past(wr_done) || $past(wr_done, 2) ||
         $past(mem_acc) || $past(mem_acc, 2))
        else $error("store interrupt moved without a cause");
    cv_message: cover property (msg_valid_q && msg_ready);
    cv_store: cover property (mem_acc);
    cv_step: cover property (step_trap_q);
    cv_irq: cover property ($rose(trace_irq_q));
endmodule
bind btr_top btr_monitor btr_monitor_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pready_q(pready_q), .ev_valid(ev_valid),
    .core_ready_q(core_ready_q), .step_trap_q(step_trap_q),
    .trace_irq_q(trace_irq_q), .msg_valid_q(msg_valid_q),
    .msg_from_q(msg_from_q), .msg_to_q(msg_to_q), .msg_ready(msg_ready),
    .mem_valid_q(mem_valid_q), .mem_addr_q(mem_addr_q),
    .mem_data_q(mem_data_q), .mem_ready(mem_ready)
);
`default_nettype wire

// >>> tb/btr_sink.sv
// Far-side model: bus trace monitor and store memory with random stalls.
`default_nettype none
module btr_sink (
    input  wire logic        pclk,
    input  wire logic        msg_valid,
    input  wire logic [63:0] msg_rec,
    output logic             msg_ready,
    input  wire logic        mem_valid,
    input  wire logic [95:0] mem_req,
    output logic             mem_ready
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [63:0] msgs[$];
    logic [95:0] mems[$];
    initial begin
        msg_ready = 1'b0;
        mem_ready = 1'b0;
    end
    always @(posedge pclk) begin
        if (msg_valid && msg_ready)
            msgs.push_back(msg_rec);
        if (mem_valid && mem_ready)
            mems.push_back(mem_req);
        msg_ready <= ($urandom % 3) == 0;
        mem_ready <= ($urandom % 3) == 0;
    end
endmodule
`default_nettype wire

// >>> tb/btr_top_tb.sv
// Self-checking bench for the branch trace recorder.
`default_nettype none
module btr_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        pclk, presetn, psel, penable, pwrite, pready_q, pslverr_q;
    logic        ev_valid, ev_with_branch, dbg_exc, core_ready_q, step_trap_q;
    logic        trace_irq_q, msg_valid_q, msg_ready, mem_valid_q, mem_ready;
    logic [31:0] paddr, pwdata, prdata_q, ev_from, ev_to, ev_br_from, ev_br_to;
    logic [31:0] msg_from_q, msg_to_q, mem_addr_q, base, idx, amax, rdat;
    logic [63:0] mem_data_q, ler, lastbr, stk[4], expm[$];
    logic [95:0] expw[$];
    logic [4:0]  ctl;
    logic [1:0]  ev_kind, stack_top_pointer;
    logic        trap, perr;
    int          fails, comparisons;
    btr_top btr_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pready_q(pready_q), .prdata_q(prdata_q), .pslverr_q(pslverr_q),
        .ev_valid(ev_valid), .ev_kind(ev_kind), .ev_from(ev_from),
        .ev_to(ev_to), .ev_with_branch(ev_with_branch),
        .ev_br_from(ev_br_from), .ev_br_to(ev_br_to), .dbg_exc(dbg_exc),
        .core_ready_q(core_ready_q), .step_trap_q(step_trap_q),
        .trace_irq_q(trace_irq_q), .msg_valid_q(msg_valid_q),
        .msg_from_q(msg_from_q), .msg_to_q(msg_to_q), .msg_ready(msg_ready),
        .mem_valid_q(mem_valid_q), .mem_addr_q(mem_addr_q),
        .mem_data_q(mem_data_q), .mem_ready(mem_ready));
    btr_sink btr_sink_inst (.pclk(pclk), .msg_valid(msg_valid_q),
        .msg_rec({msg_to_q, msg_from_q}), .msg_ready(msg_ready),
        .mem_valid(mem_valid_q), .mem_req({mem_addr_q, mem_data_q}),
        .mem_ready(mem_ready));
    always #5 pclk = ~pclk;
    task automatic conclude();
        if (fails == 0 && comparisons > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic give_up();
        fails++;
        $display("ERROR %0t: wait ran out", $time);
        conclude();
    endtask
    task automatic check(input logic [95:0] seen, input logic [95:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fails++;
            $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int n;
        n = 0;
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= {24'h00_0000, a};
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready_q !== 1'b1 && n < 50);
        rdat = prdata_q;
        perr = pslverr_q;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
        if (n >= 50)
            give_up();
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
        case (a)
            btr_pkg::OFF_CTRL:   ctl = d[4:0];
            btr_pkg::OFF_TRAP:   trap = d[0];
            btr_pkg::OFF_BASE:   base = d;
            btr_pkg::OFF_INDEX:  idx = d;
            btr_pkg::OFF_ABSMAX: amax = d;
            default: ;
        endcase
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0000_0000);
        check(rdat, e);
    endtask
    function automatic void push(input logic [63:0] x);
        stack_top_pointer      = stack_top_pointer + 2'h1;
        stk[stack_top_pointer] = x;
    endfunction
    function automatic void emit(input logic [63:0] x);
        if (!ctl[3])
            expm.push_back(x);
        else if (!(ctl[4] && idx >= amax)) begin
            expw.push_back({idx, x});
            idx = idx + 32'h0000_0008;
            if (!ctl[4] && idx >= amax)
                idx = base;
        end
    endfunction
    task automatic ev(input logic [1:0] k, input logic wb);
        logic [63:0] r, b;
        int          n;
        r = {$urandom, $urandom};
        b = {$urandom, $urandom};
        n = 0;
        ev_valid <= 1'b1;
        ev_kind <= k;
        {ev_to, ev_from} <= r;
        ev_with_branch <= wb;
        {ev_br_to, ev_br_from} <= b;
        do begin
            @(posedge pclk);
            n++;
        end while (core_ready_q !== 1'b1 && n < 50);
        ev_valid <= 1'b0;
        if (n >= 50)
            give_up();
        wb = wb && k != 2'b00;
        if (ctl[0]) begin
            if (wb)
                push(b);
            if (k != 2'b00)
                ler = wb ? b : lastbr;
            lastbr = wb ? b : lastbr;
            push(r);
            lastbr = (k == 2'b00) ? r : lastbr;
        end
        if (ctl[2] && wb)
            emit(b);
        if (ctl[2])
            emit(r);
        @(posedge pclk);
        check(step_trap_q, ctl[1] && trap);
    endtask
    task automatic dbg();
        dbg_exc <= 1'b1;
        @(posedge pclk);
        dbg_exc <= 1'b0;
        ctl[0] = 1'b0;
        trap = ctl[1] ? 1'b0 : trap;
        ctl[1] = 1'b0;
    endtask
    task automatic stack_ler();
        for (int i = 0; i < 4; i++) begin
            rd(8'(btr_pkg::OFF_STACK + 8 * i), stk[i][31:0]);
            rd(8'(btr_pkg::OFF_STACK + 8 * i + 4), stk[i][63:32]);
        end
        rd(btr_pkg::OFF_TOS, {30'h0000_0000, stack_top_pointer});
        rd(btr_pkg::OFF_LER_DST, ler[63:32]);
        rd(btr_pkg::OFF_LER_SRC, ler[31:0]);
    endtask
    task automatic drain();
        int n;
        n = 0;
        repeat (8) @(posedge pclk);
        while ((btr_sink_inst.msgs.size() != expm.size() ||
                btr_sink_inst.mems.size() != expw.size()) && n < 500) begin
            @(posedge pclk);
            n++;
        end
        if (n >= 500)
            give_up();
        repeat (2) @(posedge pclk);
        while (expm.size() > 0)
            check(btr_sink_inst.msgs.pop_front(), expm.pop_front());
        while (expw.size() > 0)
            check(btr_sink_inst.mems.pop_front(), expw.pop_front());
    endtask
    initial begin
        {pclk, presetn, psel, penable, pwrite, ev_valid, dbg_exc} = '0;
        {ev_with_branch, paddr, pwdata, ev_kind, ev_from, ev_to} = '0;
        {ev_br_from, ev_br_to, ctl, stack_top_pointer, trap, ler, lastbr} = '0;
        {base, idx, amax} = '0;
        stk = '{default: '0};
        fails = 0;
        comparisons = 0;
        rdat = $urandom(32'h0000_fc84);
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rd(btr_pkg::OFF_CTRL, 32'h0000_0000);
        rd(btr_pkg::OFF_CAP, 32'h0020_0000);
        rd(btr_pkg::OFF_MISC, 32'h0000_0000);
        rd(8'h50, 32'h0000_0000);
        check(perr, 1'b1);
        wr(btr_pkg::OFF_CTRL, 32'h0000_0001);
        repeat (6) ev(2'b00, 1'b0);
        ev(2'b01, 1'b0);
        stack_ler();
        ev(2'b10, 1'b1);
        stack_ler();
        dbg();
        rd(btr_pkg::OFF_CTRL, ctl);
        ev(2'b00, 1'b0);
        stack_ler();
        wr(btr_pkg::OFF_CTRL, 32'h0000_0003);
        wr(btr_pkg::OFF_TRAP, 32'h0000_0001);
        ev(2'b01, 1'b0);
        dbg();
        rd(btr_pkg::OFF_CTRL, ctl);
        rd(btr_pkg::OFF_TRAP, trap);
        wr(btr_pkg::OFF_CTRL, 32'h0000_0002);
        ev(2'b10, 1'b1);
        wr(btr_pkg::OFF_CTRL, 32'h0000_0005);
        repeat (12) ev(2'($urandom % 3), 1'($urandom));
        drain();
        stack_ler();
        wr(btr_pkg::OFF_CTRL, 32'h0000_0001);
        ev(2'b01, 1'b1);
        drain();
        wr(btr_pkg::OFF_SAP, 32'h0000_0800);
        wr(btr_pkg::OFF_BASE, 32'h0000_1000);
        wr(btr_pkg::OFF_INDEX, 32'h0000_1000);
        wr(btr_pkg::OFF_ABSMAX, 32'h0000_1020);
        wr(btr_pkg::OFF_THRESH, 32'h0000_1010);
        wr(btr_pkg::OFF_CTRL, 32'h0000_000C);
        repeat (5) ev(2'b00, 1'b0);
        ev(2'b01, 1'b1);
        drain();
        rd(btr_pkg::OFF_INDEX, idx);
        wr(btr_pkg::OFF_INDEX, base);
        wr(btr_pkg::OFF_CTRL, 32'h0000_001C);
        ev(2'b00, 1'b0);
        drain();
        check(trace_irq_q, 1'b0);
        ev(2'b00, 1'b0);
        drain();
        check(trace_irq_q, 1'b1);
        repeat (3) ev(2'b00, 1'b0);
        drain();
        rd(btr_pkg::OFF_CTRL, ctl);
        rd(btr_pkg::OFF_INDEX, idx);
        wr(btr_pkg::OFF_INDEX, base);
        repeat (3) @(posedge pclk);
        check(trace_irq_q, 1'b0);
        conclude();
    end
endmodule
`default_nettype wire
